// ==== logic/runaway_code_watchdog.sv ====
`timescale 1ns/1ps
// Summary of operation
// - 6-bit counter steps on carry of 12-bit oscillator prescaler.
// - without clearing, overflow forces reset after 2^18-16 or 2^13-16 cycles.
// - rate select one picks short timeout, zero picks long timeout.
// - any write to clear location zeroes 6-bit counter and prescaler stages 12..5.
// - reading clear location returns reset vector low byte, no side effect.
// - timeout drives reset pin low 32 cycles and sets watchdog cause flag.
// - stop instruction clears the prescaler.
// - power-on logic clears prescaler 4096 cycles after power-up.
// - internal reset clears prescaler and watchdog counter.
// - disable input from config bit; no watchdog reset while disabled.
// - disable bit one means disabled, zero means enabled.
// - monitor via test voltage on irq: disabled while test voltage on irq or reset.
// - monitor via blank vectors: disabled until next power-on reset.
// - in break, test voltage on reset pin suppresses the watchdog.
// - never raises a processor interrupt; timeout only resets.
// - counting continues in wait mode and resets on timeout.
// - stop mode halts counting and clears prescaler.
// - stop with stop disabled gives illegal opcode reset.
// - stop honoured only when stop enable bit is one.
module runaway_code_watchdog (
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  // ahb-lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // system side
  input  wire logic [7:0]  vector_low_in,
  input  wire logic        int_reset_in,
  input  wire logic        monitor_mode_in,
  input  wire logic        monitor_by_tst_in,
  input  wire logic        break_in,
  input  wire logic        irq_tst_in,
  input  wire logic        rst_tst_in,
  output logic             reset_n_out,
  output logic             illegal_op_reset_out,
  output logic             stop_mode_out,
  output logic             irq_out
);
  // ****************************************************
  // state
  // ****************************************************
  typedef struct packed {
    logic              ph_valid;
    logic              ph_write;
    logic [31:0]       ph_addr;
    wdg_pkg::ctrl_t    ctrl;
    logic              cause_flag;
    logic              stopped;
    logic              waiting;
    logic              blank_lock;
    logic              por_done;
    logic [12:0]       por_cnt;
    logic [5:0]        pulse_cnt;
    logic              pulsing;
    logic              illegal;
    logic [31:0]       rdata;
  } state_t;

  state_t             s_q;
  state_t             s_d;
  wdg_pkg::wdog_cmd_t cmd;
  logic               overflow;
  logic [17:0]        count;
  logic               por_clear;
  logic               wd_off;
  logic               wr_data;

  // decoding used for write and read paths
  function automatic logic is_ofs(input logic [31:0] a, input logic [31:0] ofs);
    is_ofs = (a[17:2] == ofs[17:2]);
  endfunction

  wdg_counter u_cnt (
    .clk_in         (clk_in),
    .arst_n_in      (arst_n_in),
    .int_reset_in   (int_reset_in),
    .por_clear_in   (por_clear),
    .cmd_in         (cmd),
    .rate_select_in (s_q.ctrl.rate_select),
    .overflow_out   (overflow),
    .count_out      (count)
  );

  // ****************************************************
  // combinational helpers
  // ****************************************************
  assign wr_data   = s_q.ph_valid && s_q.ph_write;
  assign por_clear = (s_q.por_cnt == 13'(wdg_pkg::POR_CYCLES - 1)) && !s_q.por_done;
  // disable terms from config, monitor and break
  assign wd_off    = s_q.ctrl.disable_bit
                   || (monitor_mode_in && monitor_by_tst_in
                       && (irq_tst_in || rst_tst_in))
                   || s_q.blank_lock
                   || (break_in && rst_tst_in);

  // commands to counter chain; clear shares the cycle of the data phase
  always_comb
  begin
    cmd.clear     = wr_data && is_ofs(s_q.ph_addr, wdg_pkg::CLEAR_OFS);
    cmd.stop_exec = wr_data && is_ofs(s_q.ph_addr, wdg_pkg::EVENT_OFS)
                    && hwdata_in[wdg_pkg::EV_STOP_BIT]
                    && s_q.ctrl.stop_enable;
    cmd.stopped   = s_q.stopped;
  end

  // ****************************************************
  // next state
  // ****************************************************
  always_comb
  begin
    s_d         = s_q;
    s_d.illegal = 1'b0;
    // address phase capture; zero wait state slave
    if (hready_in)
    begin
      s_d.ph_valid = hsel_in && htrans_in[1];
      s_d.ph_write = hwrite_in;
      s_d.ph_addr  = haddr_in;
      s_d.rdata    = 32'h0000_0000;
      if (hsel_in && htrans_in[1] && !hwrite_in)
      begin
        // reading clear location has no side effect
        if (is_ofs(haddr_in, wdg_pkg::CLEAR_OFS))
          s_d.rdata = {24'h000000, vector_low_in};
        else if (is_ofs(haddr_in, wdg_pkg::CTRL_OFS))
          s_d.rdata = {29'h0, s_q.ctrl.stop_enable, s_q.ctrl.rate_select,
                       s_q.ctrl.disable_bit};
        else if (is_ofs(haddr_in, wdg_pkg::STATUS_OFS))
          s_d.rdata = {8'h00, count, s_q.blank_lock, s_q.waiting, s_q.stopped,
                       wd_off, s_q.pulsing, s_q.cause_flag};
      end
    end
    // register writes
    if (wr_data && is_ofs(s_q.ph_addr, wdg_pkg::CTRL_OFS))
    begin
      s_d.ctrl.disable_bit = hwdata_in[wdg_pkg::CTRL_DISABLE_BIT];
      s_d.ctrl.rate_select = hwdata_in[wdg_pkg::CTRL_RATE_BIT];
      s_d.ctrl.stop_enable = hwdata_in[wdg_pkg::CTRL_STOPEN_BIT];
    end
    if (wr_data && is_ofs(s_q.ph_addr, wdg_pkg::STATUS_OFS) && hwdata_in[0])
    begin
      s_d.cause_flag = 1'b0; // cleared by write one
    end
    if (wr_data && is_ofs(s_q.ph_addr, wdg_pkg::EVENT_OFS))
    begin
      if (hwdata_in[wdg_pkg::EV_STOP_BIT])
      begin
        if (s_q.ctrl.stop_enable)
          s_d.stopped = 1'b1;
        else
          s_d.illegal = 1'b1;
      end
      if (hwdata_in[wdg_pkg::EV_WAIT_BIT])
        s_d.waiting = 1'b1;
      if (hwdata_in[wdg_pkg::EV_WAKE_BIT])
      begin
        s_d.stopped = 1'b0;
        s_d.waiting = 1'b0;
      end
    end
    // power-on counter
    if (!s_q.por_done)
    begin
      s_d.por_cnt = s_q.por_cnt + 13'h0001;
      if (por_clear)
        s_d.por_done = 1'b1;
    end
    // blank-vector monitor entry latches off until power-on
    if (monitor_mode_in && !monitor_by_tst_in)
      s_d.blank_lock = 1'b1;
    // reset pulse
    if (s_q.pulsing)
    begin
      s_d.pulse_cnt = s_q.pulse_cnt + 6'h01;
      if (s_q.pulse_cnt == 6'(wdg_pkg::RST_PULSE_CYCLES - 1))
      begin
        s_d.pulsing   = 1'b0;
        s_d.pulse_cnt = 6'h00;
      end
    end
    else if (overflow && !wd_off)
    begin
      s_d.pulsing    = 1'b1;
      s_d.cause_flag = 1'b1;                     // set wins over clear
      s_d.stopped    = 1'b0;
      s_d.waiting    = 1'b0;
    end
    if (int_reset_in)
    begin
      s_d.stopped = 1'b0;
      s_d.waiting = 1'b0;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign hreadyout_out        = 1'b1;
  assign hresp_out            = 1'b0;
  assign hrdata_out           = s_q.rdata;
  assign reset_n_out          = !s_q.pulsing;
  assign illegal_op_reset_out = s_q.illegal;
  assign stop_mode_out        = s_q.stopped;
  assign irq_out              = 1'b0;

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s_q      <= '0;
      s_q.ctrl <= wdg_pkg::CTRL_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end
endmodule

// ==== logic/wdg_counter.sv ====
`timescale 1ns/1ps
// ****************************************************
// prescaler and watchdog counter chain
// ****************************************************
module wdg_counter (
  input  wire logic              clk_in,
  input  wire logic              arst_n_in,
  input  wire logic              int_reset_in,
  input  wire logic              por_clear_in,
  input  wire wdg_pkg::wdog_cmd_t cmd_in,
  input  wire logic              rate_select_in,
  output logic                   overflow_out,
  output logic [17:0]            count_out
);
  typedef struct packed {
    logic [wdg_pkg::PRESCALE_W-1:0] pre;
    logic [wdg_pkg::WDOG_W-1:0]     wdog;
  } cnt_state_t;

  cnt_state_t s_q;
  cnt_state_t s_d;
  logic       carry;

  // next state of both stages
  always_comb
  begin
    s_d   = s_q;
    carry = 1'b0;
    if (int_reset_in)
    begin
      s_d = '0;
    end
    else if (cmd_in.stop_exec || por_clear_in)
    begin
      s_d.pre = '0;
    end
    else if (cmd_in.clear)
    begin
      s_d.wdog = '0;
      s_d.pre[wdg_pkg::PRESCALE_W-1:wdg_pkg::CLR_LOW_BIT] = '0;
    end
    else if (!cmd_in.stopped)
    begin
      // stopped gates the oscillator clock off
      carry   = &s_q.pre;
      s_d.pre = s_q.pre + 1'b1;
      if (carry)
      begin
        s_d.wdog = s_q.wdog + 1'b1;
      end
    end
  end

  // overflow one cycle before wrap; -16 comes from bits 3..0 not being cleared
  always_comb
  begin
    if (rate_select_in)
    begin
      // first pass with wdog at one ends 2^13-16 after clear
      overflow_out = s_q.wdog[0] && (&s_q.pre) && !cmd_in.stopped;
    end
    else
    begin
      overflow_out = (&s_q.wdog) && (&s_q.pre) && !cmd_in.stopped;
    end
  end

  assign count_out = {s_q.wdog, s_q.pre};

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
endmodule

// ==== logic/wdg_pkg.sv ====
package wdg_pkg;

  // ****************************************************
  // register map (byte addresses on the bus)
  // ****************************************************
  localparam logic [15:0] CLEAR_ADDR      = 16'hFFFF; // clear location, overlaps vector
  localparam logic [31:0] CLEAR_OFS       = 32'h0003_FFFC; // word index FFFF times four
  localparam logic [31:0] CTRL_OFS        = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFS      = 32'h0000_0004;
  localparam logic [31:0] EVENT_OFS       = 32'h0000_0008;

  // ctrl field positions
  localparam int CTRL_DISABLE_BIT = 0;
  localparam int CTRL_RATE_BIT    = 1;
  localparam int CTRL_STOPEN_BIT  = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // event register bits (write one = pulse)
  localparam int EV_STOP_BIT = 0;
  localparam int EV_WAIT_BIT = 1;
  localparam int EV_WAKE_BIT = 2;

  // ****************************************************
  // counter sizes and timing
  // ****************************************************
  localparam int PRESCALE_W   = 12;
  localparam int WDOG_W       = 6;
  localparam int CLR_LOW_BIT  = 4; // stages 12..5 are bits 11..4
  localparam int SHORT_TAP    = 6; // 2^13: carry of 2^12 prescaler, 1 count -> bit 0 of wdog, then one more pass
  localparam int RST_PULSE_CYCLES = 32;
  localparam int POR_CYCLES       = 4096;
  localparam logic [7:0] VECTOR_LOW_RESET = 8'h00; // arbitrary default vector byte

  // ****************************************************
  // carriers
  // ****************************************************
  typedef struct packed {
    logic disable_bit;
    logic rate_select;
    logic stop_enable;
  } ctrl_t;

  typedef struct packed {
    logic clear;
    logic stop_exec;
    logic stopped;
  } wdog_cmd_t;

endpackage

// ==== tb/cpu_model.sv ====
`timescale 1ns/1ps
// ****
// processor bus master model
// ****
module cpu_model (
  input  wire logic        clk_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hrdata_in,
  output logic             hsel_out,
  output logic [31:0]      haddr_out,
  output logic [1:0]       htrans_out,
  output logic             hwrite_out,
  output logic [2:0]       hsize_out,
  output logic [31:0]      hwdata_out
);
  // idle bus from time zero
  initial
  begin
    hsel_out   = 1'b0;
    haddr_out  = 32'h0000_0000;
    htrans_out = 2'h0;
    hwrite_out = 1'b0;
    hsize_out  = 3'h2;
    hwdata_out = 32'h0000_0000;
  end
  // single word transfer; clears come from main flow, not handlers
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic ok);
    int n;
    hsel_out   <= 1'b1;
    haddr_out  <= a;
    htrans_out <= 2'h2;
    hwrite_out <= w;
    n = 0;
    do @(posedge clk_in); while (hready_in !== 1'b1 && ++n < 64);
    htrans_out <= 2'h0;
    hsel_out   <= 1'b0;
    hwdata_out <= d;
    do @(posedge clk_in); while (hready_in !== 1'b1 && ++n < 128);
    r  = hrdata_in;
    ok = hready_in === 1'b1;
    // stale data is not left on the bus
    hwdata_out <= ~d;
  endtask
endmodule

// ==== tb/runaway_code_watchdog_tb.sv ====
`timescale 1ns/1ps
// ****
// watchdog bench
// ****
module runaway_code_watchdog_tb;
  logic clk_in, arst_n_in, hsel_in, hwrite_in, hready_in, hreadyout_out, hresp_out;
  logic int_reset_in, monitor_mode_in, monitor_by_tst_in, break_in, irq_tst_in, rst_tst_in;
  logic reset_n_out, illegal_op_reset_out, stop_mode_out, irq_out;
  logic [31:0] haddr_in, hwdata_in, hrdata_out;
  logic [1:0]  htrans_in;
  logic [2:0]  hsize_in;
  logic [7:0]  vector_low_in;
  int          mismatches, samples_checked;
  assign hready_in = hreadyout_out;
  runaway_code_watchdog u_dut (.*);
  cpu_model u_cpu (.clk_in(clk_in), .hready_in(hready_in), .hrdata_in(hrdata_out),
    .hsel_out(hsel_in), .haddr_out(haddr_in), .htrans_out(htrans_in),
    .hwrite_out(hwrite_in), .hsize_out(hsize_in), .hwdata_out(hwdata_in));
  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  task give_verdict;
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  // a hung bus cuts the run short
  task xf(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    logic ok;
    u_cpu.xfer(w, a, d, r, ok);
    cmp(ok, 1);
    if (ok !== 1'b1)
      give_verdict();
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    xf(1'b1, a, d, r);
  endtask
  task watch(input int n, output int t);
    t = -1;
    for (int i = 0; i < n && t < 0; i++)
    begin
      @(posedge clk_in);
      if (reset_n_out === 1'b0)
        t = i;
    end
  endtask
  task t_regs;
    logic [31:0] s;
    xf(1'b0, wdg_pkg::CTRL_OFS, 0, s);
    cmp(s, 0);
    wr(32'h0000_0100, 32'hFFFF_FFFF);
    xf(1'b0, 32'h0000_0100, 0, s);
    cmp(s, 0);
    xf(1'b0, wdg_pkg::CLEAR_OFS, 0, s);
    cmp(s, 32'h0000_00A5);
  endtask
  task t_short;
    int t, n;
    logic [31:0] s;
    wr(wdg_pkg::CTRL_OFS, 2);
    wr(wdg_pkg::EVENT_OFS, 2);
    wr(wdg_pkg::CLEAR_OFS, 0);
    watch(8300, t);
    cmp(t >= 8150 && t <= 8200, 1);
    n = 0;
    while (reset_n_out === 1'b0 && n < 40)
    begin
      @(posedge clk_in);
      n++;
    end
    cmp(n, 32);
    xf(1'b0, wdg_pkg::STATUS_OFS, 0, s);
    cmp(s[0], 1);
    cmp(irq_out, 0);
    wr(wdg_pkg::STATUS_OFS, 1);
    wr(wdg_pkg::EVENT_OFS, 4);
    int_reset_in <= 1'b1;
    @(posedge clk_in);
    int_reset_in <= 1'b0;
    xf(1'b0, wdg_pkg::STATUS_OFS, 0, s);
    cmp(s[23:10], 0);
  endtask
  task t_clear;
    int t;
    wr(wdg_pkg::CTRL_OFS, 2);
    repeat (3)
    begin
      wr(wdg_pkg::CLEAR_OFS, 0);
      watch(6000, t);
      cmp(t, -1);
    end
  endtask
  task t_off;
    int t;
    for (int k = 0; k < 3; k++)
    begin
      wr(wdg_pkg::CTRL_OFS, k == 0 ? 3 : 2);
      monitor_mode_in   <= k == 1;
      monitor_by_tst_in <= k == 1;
      irq_tst_in        <= k == 1;
      break_in          <= k == 2;
      rst_tst_in        <= k == 2;
      wr(wdg_pkg::CLEAR_OFS, 0);
      watch(8300, t);
      cmp(t, -1);
    end
    break_in   <= 1'b0;
    rst_tst_in <= 1'b0;
  endtask
  task t_stop;
    int t, n;
    wr(wdg_pkg::CTRL_OFS, 2);
    wr(wdg_pkg::EVENT_OFS, 1);
    n = 0;
    repeat (4)
    begin
      @(posedge clk_in);
      n += illegal_op_reset_out === 1'b1;
    end
    cmp(n, 1);
    cmp(stop_mode_out, 0);
    wr(wdg_pkg::CTRL_OFS, 6);
    wr(wdg_pkg::CLEAR_OFS, 0);
    wr(wdg_pkg::EVENT_OFS, 1);
    repeat (2) @(posedge clk_in);
    cmp(stop_mode_out, 1);
    watch(8300, t);
    cmp(t, -1);
    wr(wdg_pkg::EVENT_OFS, 4);
    repeat (2) @(posedge clk_in);
    cmp(stop_mode_out, 0);
  endtask
  // blank-vector lock holds until power-on; power-on clear then delays the timeout
  task t_blank;
    int t;
    monitor_mode_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    monitor_mode_in <= 1'b0;
    wr(wdg_pkg::CTRL_OFS, 2);
    wr(wdg_pkg::CLEAR_OFS, 0);
    watch(8300, t);
    cmp(t, -1);
    arst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
    wr(wdg_pkg::CTRL_OFS, 2);
    wr(wdg_pkg::CLEAR_OFS, 0);
    watch(13000, t);
    cmp(t > 12000 && t < 12400, 1);
  endtask
  // main sequence
  initial
  begin
    arst_n_in = 1'b0;
    int_reset_in = 1'b0;
    monitor_mode_in = 1'b0;
    monitor_by_tst_in = 1'b0;
    break_in = 1'b0;
    irq_tst_in = 1'b0;
    rst_tst_in = 1'b0;
    vector_low_in = 8'hA5;
    repeat (20) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
    t_regs();
    repeat (4100) @(posedge clk_in);
    t_short();
    t_clear();
    t_off();
    t_stop();
    t_blank();
    give_verdict();
  end
endmodule

// ==== tb/wdg_sva.sv ====
`timescale 1ns/1ps
// ****
// watchdog port checker
// ****
module wdg_sva (
  input wire logic        clk_in,
  input wire logic        arst_n_in,
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic        hready_in,
  input wire logic [7:0]  vector_low_in,
  input wire logic        int_reset_in,
  input wire logic        monitor_mode_in,
  input wire logic        monitor_by_tst_in,
  input wire logic        break_in,
  input wire logic        irq_tst_in,
  input wire logic        rst_tst_in,
  input wire logic [31:0] hrdata_out,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  input wire logic        reset_n_out,
  input wire logic        illegal_op_reset_out,
  input wire logic        stop_mode_out,
  input wire logic        irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  logic [5:0]  low_q;
  logic [13:0] since_q;
  logic        clr_q;
  logic        acc;
  assign acc = hsel_in && hready_in && htrans_in[1] && haddr_in == wdg_pkg::CLEAR_OFS;
  // pulse length and cycles since the last clear or internal reset; the latter saturates so long runs never wrap
  always_ff @(posedge clk_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      low_q   <= 6'h00;
      since_q <= 14'h0000;
      clr_q   <= 1'b0;
    end
    else
    begin
      low_q   <= reset_n_out ? 6'h00 : low_q + 6'h01;
      clr_q   <= acc && hwrite_in;
      since_q <= (clr_q || int_reset_in) ? 14'h0000 : since_q + {13'h0000, ~&since_q};
    end
  irq_never_a: assert property (!irq_out) else $error("irq raised");
  bus_okay_a: assert property (hreadyout_out && !hresp_out) else $error("bus not okay");
  clr_read_a: assert property (acc && !hwrite_in |=> hrdata_out == {24'h000000, $past(vector_low_in)})
    else $error("clear read data");
  pulse_len_a: assert property ($rose(reset_n_out) |-> low_q == 6'h20)
    else $error("pulse length");
  timeout_min_a: assert property ($fell(reset_n_out) |-> since_q >= 14'h1FE0)
    else $error("timeout early");
  tst_off_a: assert property ($fell(reset_n_out) |-> !$past((monitor_mode_in && monitor_by_tst_in
    && (irq_tst_in || rst_tst_in)) || (break_in && rst_tst_in))) else $error("reset while suppressed");
  stop_hold_a: assert property ($fell(reset_n_out) |-> !$past(stop_mode_out))
    else $error("reset in stop");
  illegal_one_a: assert property (illegal_op_reset_out |=> !illegal_op_reset_out)
    else $error("illegal pulse long");
endmodule
bind runaway_code_watchdog wdg_sva u_sva (.*);
